// ---- ewf_pkg.sv ----
// constants shared by the external and wakeup interrupt flag block
package ewf_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned EXT_N = 2;
  localparam int unsigned WAKE_N = 6;
  localparam int unsigned EVT_N = 9;
  // register byte offsets
  localparam logic [7:0] OFF_EXT_FLAGS = 8'h00;
  localparam logic [7:0] OFF_WAKE_FLAGS = 8'h04;
  localparam logic [7:0] OFF_EDGE_SEL_1 = 8'h08;
  localparam logic [7:0] OFF_EDGE_SEL_2 = 8'h0C;
  localparam logic [7:0] OFF_INT_ENABLE = 8'h10;
  localparam logic [7:0] OFF_EXT_PIN_MODE = 8'h14;
  localparam logic [7:0] OFF_WAKE_PIN_MODE = 8'h18;
  localparam logic [7:0] OFF_SYS_CTRL_2 = 8'h1C;
  localparam logic [7:0] OFF_EVT_STATUS = 8'h20;
  localparam logic [7:0] OFF_EVT_MASK = 8'h24;
  // bit positions in the flag, edge, enable, pin mode and system control 2 bytes
  localparam int unsigned BIT_DT = 7;
  localparam int unsigned BIT_RSVD_ZERO = 6;
  localparam int unsigned BIT_WAKE_EN = 5;
  localparam int unsigned BIT_I3 = 3;
  localparam int unsigned BIT_I0 = 0;
  localparam int unsigned BIT_DT_ENABLE = 3;
  // event status layout
  localparam int unsigned EVT_DT = 8;
  localparam int unsigned EVT_I3 = 7;
  localparam int unsigned EVT_I0 = 6;
  // fixed read patterns of reserved bits
  localparam logic [7:0] EXT_FLAGS_ONES = 8'h30;
  localparam logic [7:0] WAKE_FLAGS_ONES = 8'hC0;
  localparam logic [7:0] EDGE_SEL_1_ONES = 8'h70;
  localparam logic [7:0] EDGE_SEL_2_ONES = 8'hC0;
  localparam logic [7:0] INT_ENABLE_ONES = 8'h10;
  // reset values
  localparam logic [EXT_N-1:0] EXT_RST = 2'h0;
  localparam logic [WAKE_N-1:0] WAKE_RST = 6'h00;
  localparam logic [EVT_N-1:0] EVT_RST = 9'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
endpackage

// ---- ewf_reg_if.sv ----
// register access carrier between the bus slave and the flag logic
`timescale 1ns/10ps
`default_nettype none
interface ewf_reg_if;
  logic [ewf_pkg::ADDR_W-1:0] addr;
  logic [ewf_pkg::DATA_W-1:0] wdata;
  logic wr_stb;
  logic [ewf_pkg::DATA_W-1:0] rdata;
  logic hit;
  modport bus
  (
    output addr,
    output wdata,
    output wr_stb,
    input rdata,
    input hit
  );
  modport regs
  (
    input addr,
    input wdata,
    input wr_stb,
    output rdata,
    output hit
  );
endinterface
`default_nettype wire

// ---- ewf_edge_det.sv ----
// per-pin selectable edge detector for interrupt inputs
`timescale 1ns/10ps
`default_nettype none
module ewf_edge_det #(
  parameter int unsigned W = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // pins and settings
  input wire logic [W-1:0] pin_i,
  input wire logic [W-1:0] rise_sel_i,
  input wire logic [W-1:0] arm_i,
  // one-cycle edge hits
  output logic [W-1:0] hit_o
);
  logic [W-1:0] prev_r;
  logic vld_r;

  // no edge is reported before the first sample after reset
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prev_r <= '0;
      vld_r <= 1'b0;
    end
    else
    begin
      prev_r <= pin_i;
      vld_r <= 1'b1;
    end
  end

  // select 1 takes the rising edge, 0 the falling edge
  assign hit_o = arm_i & {W{vld_r}} &
    ((rise_sel_i & pin_i & ~prev_r) | (~rise_sel_i & ~pin_i & prev_r));
endmodule
`default_nettype wire

// ---- ewf_apb_slave.sv ----
// apb slave with no wait state, registered answer
`timescale 1ns/10ps
`default_nettype none
module ewf_apb_slave (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ewf_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [ewf_pkg::DATA_W-1:0] pwdata_i,
  output logic [ewf_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // register side
  ewf_reg_if.bus rif
);
  import ewf_pkg::*;
  logic pready_r;
  logic pslverr_r;
  logic [DATA_W-1:0] prdata_r;
  logic setup;

  assign setup = psel_i & ~penable_i;
  assign rif.addr = paddr_i;
  assign rif.wdata = pwdata_i;
  // a write takes effect only at the edge that completes the access
  assign rif.wr_stb = psel_i & penable_i & pready_r & pwrite_i;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pready_r <= 1'b0;
    else
      pready_r <= setup;
  end

  // read data and error are captured in the setup cycle
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prdata_r <= DATA_RST;
      pslverr_r <= 1'b0;
    end
    else if (setup)
    begin
      prdata_r <= pwrite_i ? DATA_RST : rif.rdata;
      pslverr_r <= ~rif.hit;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
endmodule
`default_nettype wire

// ---- ewf_ext_wakeup_irq_flags.sv ----
// external and wakeup interrupt request flags with apb registers
// Functional notes
// - sleep with direct transition enabled sets the direct-transition flag.
// - writing 0 to bit 7 clears the direct-transition flag.
// - bit 6 of the external flag register reads as 0.
// - bits 5,4 of external flags and 7,6 of wakeup flags read 1.
// - bits 2 and 1 of the external flag register read as 0.
// - selected edge on armed pin 3 sets external flag bit 3.
// - selected edge on armed pin 0 sets external flag bit 0.
// - writing 0 to bit 3 or bit 0 clears that external flag.
// - selected edge on armed wake pin n sets wakeup flag bit n.
// - writing 0 clears only that wakeup flag, others unaffected.
// - all request flags are 0 after reset.
// - edge select 0 means falling, 1 means rising, per pin.
// - one common enable gates all six wake flags; ext pins own enables.
`timescale 1ns/10ps
`default_nettype none
module ewf_ext_wakeup_irq_flags (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ewf_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [ewf_pkg::DATA_W-1:0] pwdata_i,
  output logic [ewf_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // pins and sleep event
  input wire logic ext_int_pin_3_i,
  input wire logic ext_int_pin_0_i,
  input wire logic [ewf_pkg::WAKE_N-1:0] wake_pin_i,
  input wire logic sleep_direct_i,
  // requests toward the cpu
  output logic direct_transition_req_o,
  output logic ext_int_3_req_o,
  output logic ext_int_0_req_o,
  output logic wakeup_req_o,
  output logic irq_o
);
  import ewf_pkg::*;

  ewf_reg_if u_rif();

  logic direct_transition_flag_r;
  logic [EXT_N-1:0] ext_flag_r;
  logic [WAKE_N-1:0] wake_flag_r;
  logic [EXT_N-1:0] ext_edge_sel_r;
  logic [WAKE_N-1:0] wake_edge_sel_r;
  logic [EXT_N-1:0] ext_enable_r;
  logic dt_enable_r;
  logic wakeup_common_enable_r;
  logic [EXT_N-1:0] ext_pin_mode_r;
  logic [WAKE_N-1:0] wake_pin_mode_r;
  logic direct_transition_enable_r;
  logic [EVT_N-1:0] evt_status_r;
  logic [EVT_N-1:0] evt_mask_r;
  logic dt_req_r;
  logic i3_req_r;
  logic i0_req_r;
  logic wake_req_r;
  logic irq_r;
  logic [EXT_N-1:0] ext_set;
  logic [WAKE_N-1:0] wake_set;
  logic dt_set;
  logic [EVT_N-1:0] evt_set;
  logic [EXT_N-1:0] ext_keep;
  logic [WAKE_N-1:0] wake_keep;
  logic dt_keep;
  logic [REG_W-1:0] wbyte;
  logic [REG_W-1:0] rbyte;
  logic rhit;

  function automatic logic reg_wr(input logic stb, input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] off);
    reg_wr = stb && (a == off);
  endfunction

  ewf_apb_slave u_apb (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .rif(u_rif.bus)
  );

  ewf_edge_det #(.W(EXT_N)) u_ext_edge (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i({ext_int_pin_3_i, ext_int_pin_0_i}),
    .rise_sel_i(ext_edge_sel_r),
    .arm_i(ext_pin_mode_r),
    .hit_o(ext_set)
  );

  ewf_edge_det #(.W(WAKE_N)) u_wake_edge (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(wake_pin_i),
    .rise_sel_i(wake_edge_sel_r),
    .arm_i(wake_pin_mode_r),
    .hit_o(wake_set)
  );

  assign wbyte = u_rif.wdata[REG_W-1:0];
  assign dt_set = sleep_direct_i & direct_transition_enable_r;
  assign evt_set = {dt_set, ext_set, wake_set};

  // a flag keeps its value unless its bit is written with 0
  assign dt_keep = ~reg_wr(u_rif.wr_stb, u_rif.addr, OFF_EXT_FLAGS) | wbyte[BIT_DT];
  assign ext_keep = reg_wr(u_rif.wr_stb, u_rif.addr, OFF_EXT_FLAGS) ?
                    {wbyte[BIT_I3], wbyte[BIT_I0]} : {EXT_N{1'b1}};
  assign wake_keep = reg_wr(u_rif.wr_stb, u_rif.addr, OFF_WAKE_FLAGS) ?
                     wbyte[WAKE_N-1:0] : {WAKE_N{1'b1}};

  // set has priority over a clearing write
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      direct_transition_flag_r <= 1'b0;
      ext_flag_r <= EXT_RST;
      wake_flag_r <= WAKE_RST;
    end
    else
    begin
      direct_transition_flag_r <= dt_set | (direct_transition_flag_r & dt_keep);
      ext_flag_r <= ext_set | (ext_flag_r & ext_keep);
      wake_flag_r <= wake_set | (wake_flag_r & wake_keep);
    end
  end

  // control registers
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ext_edge_sel_r <= EXT_RST;
      wake_edge_sel_r <= WAKE_RST;
      ext_enable_r <= EXT_RST;
      dt_enable_r <= 1'b0;
      wakeup_common_enable_r <= 1'b0;
      ext_pin_mode_r <= EXT_RST;
      wake_pin_mode_r <= WAKE_RST;
      direct_transition_enable_r <= 1'b0;
      evt_mask_r <= EVT_RST;
    end
    else
    begin
      if (reg_wr(u_rif.wr_stb, u_rif.addr, OFF_EDGE_SEL_1))
        ext_edge_sel_r <= {wbyte[BIT_I3], wbyte[BIT_I0]};
      if (reg_wr(u_rif.wr_stb, u_rif.addr, OFF_EDGE_SEL_2))
        wake_edge_sel_r <= wbyte[WAKE_N-1:0];
      if (reg_wr(u_rif.wr_stb, u_rif.addr, OFF_INT_ENABLE))
      begin
        dt_enable_r <= wbyte[BIT_DT];
        wakeup_common_enable_r <= wbyte[BIT_WAKE_EN];
        ext_enable_r <= {wbyte[BIT_I3], wbyte[BIT_I0]};
      end
      if (reg_wr(u_rif.wr_stb, u_rif.addr, OFF_EXT_PIN_MODE))
        ext_pin_mode_r <= {wbyte[BIT_I3], wbyte[BIT_I0]};
      if (reg_wr(u_rif.wr_stb, u_rif.addr, OFF_WAKE_PIN_MODE))
        wake_pin_mode_r <= wbyte[WAKE_N-1:0];
      if (reg_wr(u_rif.wr_stb, u_rif.addr, OFF_SYS_CTRL_2))
        direct_transition_enable_r <= wbyte[BIT_DT_ENABLE];
      if (reg_wr(u_rif.wr_stb, u_rif.addr, OFF_EVT_MASK))
        evt_mask_r <= u_rif.wdata[EVT_N-1:0];
    end
  end

  // sticky event log, write 1 to clear, new event wins
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      evt_status_r <= EVT_RST;
    else if (reg_wr(u_rif.wr_stb, u_rif.addr, OFF_EVT_STATUS))
      evt_status_r <= evt_set | (evt_status_r & ~u_rif.wdata[EVT_N-1:0]);
    else
      evt_status_r <= evt_set | evt_status_r;
  end

  // cpu requests and interrupt line
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      dt_req_r <= 1'b0;
      i3_req_r <= 1'b0;
      i0_req_r <= 1'b0;
      wake_req_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      dt_req_r <= direct_transition_flag_r & dt_enable_r;
      i3_req_r <= ext_flag_r[1] & ext_enable_r[1];
      i0_req_r <= ext_flag_r[0] & ext_enable_r[0];
      wake_req_r <= (|wake_flag_r) & wakeup_common_enable_r;
      irq_r <= |(evt_status_r & evt_mask_r);
    end
  end

  assign direct_transition_req_o = dt_req_r;
  assign ext_int_3_req_o = i3_req_r;
  assign ext_int_0_req_o = i0_req_r;
  assign wakeup_req_o = wake_req_r;
  assign irq_o = irq_r;

  // read decode
  always_comb
  begin
    rbyte = '0;
    rhit = 1'b1;
    if (u_rif.addr == OFF_EXT_FLAGS)
    begin
      rbyte = EXT_FLAGS_ONES;
      rbyte[BIT_DT] = direct_transition_flag_r;
      rbyte[BIT_I3] = ext_flag_r[1];
      rbyte[BIT_I0] = ext_flag_r[0];
    end
    else if (u_rif.addr == OFF_WAKE_FLAGS)
      rbyte = WAKE_FLAGS_ONES | {2'h0, wake_flag_r};
    else if (u_rif.addr == OFF_EDGE_SEL_1)
    begin
      rbyte = EDGE_SEL_1_ONES;
      rbyte[BIT_I3] = ext_edge_sel_r[1];
      rbyte[BIT_I0] = ext_edge_sel_r[0];
    end
    else if (u_rif.addr == OFF_EDGE_SEL_2)
      rbyte = EDGE_SEL_2_ONES | {2'h0, wake_edge_sel_r};
    else if (u_rif.addr == OFF_INT_ENABLE)
    begin
      rbyte = INT_ENABLE_ONES;
      rbyte[BIT_DT] = dt_enable_r;
      rbyte[BIT_WAKE_EN] = wakeup_common_enable_r;
      rbyte[BIT_I3] = ext_enable_r[1];
      rbyte[BIT_I0] = ext_enable_r[0];
    end
    else if (u_rif.addr == OFF_EXT_PIN_MODE)
    begin
      rbyte[BIT_I3] = ext_pin_mode_r[1];
      rbyte[BIT_I0] = ext_pin_mode_r[0];
    end
    else if (u_rif.addr == OFF_WAKE_PIN_MODE)
      rbyte = {2'h0, wake_pin_mode_r};
    else if (u_rif.addr == OFF_SYS_CTRL_2)
      rbyte[BIT_DT_ENABLE] = direct_transition_enable_r;
    else if ((u_rif.addr == OFF_EVT_STATUS) || (u_rif.addr == OFF_EVT_MASK))
      rbyte = '0;
    else
      rhit = 1'b0;
  end

  assign u_rif.hit = rhit;
  assign u_rif.rdata = (u_rif.addr == OFF_EVT_STATUS) ? {23'h0, evt_status_r} :
                       (u_rif.addr == OFF_EVT_MASK) ? {23'h0, evt_mask_r} :
                       {24'h0, rbyte};

  property p_dt_set;
    @(posedge clk_i) disable iff (!reset_n_i)
    (sleep_direct_i && direct_transition_enable_r) |=> direct_transition_flag_r;
  endproperty
  a_dt_set: assert property (p_dt_set) else $error("direct flag not set");

  property p_dt_clr;
    @(posedge clk_i) disable iff (!reset_n_i)
    (u_rif.wr_stb && u_rif.addr == OFF_EXT_FLAGS && !u_rif.wdata[BIT_DT] && !dt_set)
      |=> !direct_transition_flag_r;
  endproperty
  a_dt_clr: assert property (p_dt_clr) else $error("direct flag not cleared");

  property p_rsvd_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    (u_rif.addr == OFF_EXT_FLAGS) |-> !u_rif.rdata[BIT_RSVD_ZERO];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("bit 6 not zero");

  property p_rsvd_ones;
    @(posedge clk_i) disable iff (!reset_n_i)
    ((u_rif.addr == OFF_EXT_FLAGS) |-> (u_rif.rdata[5:4] == 2'h3)) and
    ((u_rif.addr == OFF_WAKE_FLAGS) |-> (u_rif.rdata[7:6] == 2'h3));
  endproperty
  a_rsvd_ones: assert property (p_rsvd_ones) else $error("reserved ones wrong");

  property p_rsvd_low;
    @(posedge clk_i) disable iff (!reset_n_i)
    (u_rif.addr == OFF_EXT_FLAGS) |-> (u_rif.rdata[2:1] == 2'h0);
  endproperty
  a_rsvd_low: assert property (p_rsvd_low) else $error("bits 2:1 not zero");

  property p_i3_set;
    @(posedge clk_i) disable iff (!reset_n_i)
    ext_set[1] |=> ext_flag_r[1] && $past(ext_pin_mode_r[1]);
  endproperty
  a_i3_set: assert property (p_i3_set) else $error("ext 3 flag not set");

  property p_i0_set;
    @(posedge clk_i) disable iff (!reset_n_i)
    ext_set[0] |=> ext_flag_r[0] && $past(ext_pin_mode_r[0]);
  endproperty
  a_i0_set: assert property (p_i0_set) else $error("ext 0 flag not set");

  property p_ext_clr;
    @(posedge clk_i) disable iff (!reset_n_i)
    (u_rif.wr_stb && u_rif.addr == OFF_EXT_FLAGS && ext_set == 2'h0)
      |=> ext_flag_r == ($past(ext_flag_r) & $past({u_rif.wdata[BIT_I3], u_rif.wdata[BIT_I0]}));
  endproperty
  a_ext_clr: assert property (p_ext_clr) else $error("ext flag clear wrong");

  property p_wake_set;
    @(posedge clk_i) disable iff (!reset_n_i)
    (|wake_set) |=> ((wake_flag_r & $past(wake_set)) == $past(wake_set));
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake flag not set");

  property p_wake_clr;
    @(posedge clk_i) disable iff (!reset_n_i)
    (u_rif.wr_stb && u_rif.addr == OFF_WAKE_FLAGS && wake_set == 6'h00)
      |=> wake_flag_r == ($past(wake_flag_r) & $past(u_rif.wdata[WAKE_N-1:0]));
  endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("wake clear wrong");

  property p_reset_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    !$past(reset_n_i) |-> (!direct_transition_flag_r && ext_flag_r == 2'h0 && wake_flag_r == 6'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("flags not zero at reset");

  property p_rise_sel;
    @(posedge clk_i) disable iff (!reset_n_i)
    ($past(reset_n_i) && ext_pin_mode_r[1] && ext_edge_sel_r[1] &&
     ext_int_pin_3_i && !$past(ext_int_pin_3_i)) |=> ext_flag_r[1];
  endproperty
  a_rise_sel: assert property (p_rise_sel) else $error("rising edge missed");

  property p_wake_req;
    @(posedge clk_i) disable iff (!reset_n_i)
    $past(reset_n_i) |-> (wakeup_req_o == ($past(|wake_flag_r) && $past(wakeup_common_enable_r)));
  endproperty
  a_wake_req: assert property (p_wake_req) else $error("wake request wrong");

  property p_write_one;
    @(posedge clk_i) disable iff (!reset_n_i)
    (u_rif.wr_stb && u_rif.addr == OFF_WAKE_FLAGS && u_rif.wdata[WAKE_N-1:0] == 6'h3F)
      |=> $stable(wake_flag_r) or (wake_flag_r != $past(wake_flag_r) && $past(|wake_set));
  endproperty
  a_write_one: assert property (p_write_one) else $error("write one changed flag");

  property p_set_wins;
    @(posedge clk_i) disable iff (!reset_n_i)
    (ext_set[0] && u_rif.wr_stb && u_rif.addr == OFF_EXT_FLAGS) |=> ext_flag_r[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost to clear");
endmodule
`default_nettype wire

// ---- ewf_pin_model.sv ----
// partner model driving the external interrupt and wakeup pins
`timescale 1ns/10ps
`default_nettype none
module ewf_pin_model (
  // clock
  input wire logic clk_i,
  // pin levels
  output logic ext3_o,
  output logic ext0_o,
  output logic [5:0] wake_o
);
  initial
  begin
    ext3_o = 1'b0;
    ext0_o = 1'b1;
    wake_o = 6'h00;
  end
  // levels move just after an edge and then hold, one clean transition each
  task automatic drive(input logic p3, input logic p0, input logic [5:0] w);
    @(posedge clk_i);
    ext3_o <= p3;
    ext0_o <= p0;
    wake_o <= w;
  endtask
endmodule
`default_nettype wire

// ---- ewf_ext_wakeup_irq_flags_tb.sv ----
// self-checking bench for the interrupt flag block
`timescale 1ns/10ps
`default_nettype none
module ewf_ext_wakeup_irq_flags_tb;
  import ewf_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sleep = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, dt_req, i3_req, i0_req, wk_req, irq;
  logic ext3, ext0;
  logic [5:0] wake;
  logic [31:0] seed = 32'h6E05;
  logic [31:0] tmp, rd;
  logic er;
  logic [5:0] sel, w, nw, flags, evw;
  int err_total = 0;
  int check_count = 0;
  int k;

  ewf_pin_model pm (.clk_i(clk_i), .ext3_o(ext3), .ext0_o(ext0), .wake_o(wake));
  ewf_ext_wakeup_irq_flags dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ext_int_pin_3_i(ext3),
    .ext_int_pin_0_i(ext0), .wake_pin_i(wake), .sleep_direct_i(sleep),
    .direct_transition_req_o(dt_req), .ext_int_3_req_o(i3_req), .ext_int_0_req_o(i0_req),
    .wakeup_req_o(wk_req), .irq_o(irq));

  initial
  begin
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [5:0] edge_hits(input logic [5:0] o, input logic [5:0] n,
                                           input logic [5:0] s);
    return (s & ~o & n) | (~s & o & ~n);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // pready, read data and error are taken at the rising edge that completes the access
    @(posedge clk_i);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 50)
      err_total++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic pulse_sleep();
    @(posedge clk_i);
    sleep <= 1'b1;
    @(posedge clk_i);
    sleep <= 1'b0;
    settle();
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    report_and_stop();
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdc(OFF_EXT_FLAGS, 32'h30);
    rdc(OFF_WAKE_FLAGS, 32'hC0);
    rdc(OFF_EVT_STATUS, 32'h0);
    chk({dt_req, i3_req, i0_req, wk_req, irq}, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    wr(OFF_SYS_CTRL_2, 32'hF7);
    rdc(OFF_SYS_CTRL_2, 32'h0);
    $display("test reset and map done");
    wr(OFF_EXT_PIN_MODE, 32'h09);
    wr(OFF_WAKE_PIN_MODE, 32'h3F);
    wr(OFF_EDGE_SEL_1, 32'h08);
    tmp = xs();
    sel = tmp[5:0];
    wr(OFF_EDGE_SEL_2, {26'h0, sel});
    wr(OFF_INT_ENABLE, 32'hA9);
    wr(OFF_EVT_MASK, 32'h1FF);
    rdc(OFF_EDGE_SEL_2, {24'h0, 2'b11, sel});
    pm.drive(1'b1, 1'b1, 6'h00);
    settle();
    rdc(OFF_EXT_FLAGS, 32'h38);
    chk({i3_req, i0_req}, 32'h2);
    pm.drive(1'b0, 1'b0, 6'h00);
    settle();
    rdc(OFF_EXT_FLAGS, 32'h39);
    pm.drive(1'b0, 1'b1, 6'h00);
    settle();
    rdc(OFF_EXT_FLAGS, 32'h39);
    wr(OFF_EXT_FLAGS, 32'hFF);
    rdc(OFF_EXT_FLAGS, 32'h39);
    wr(OFF_EXT_FLAGS, 32'hF7);
    rdc(OFF_EXT_FLAGS, 32'h31);
    settle();
    chk({i3_req, i0_req}, 32'h1);
    fork
      wr(OFF_EXT_FLAGS, 32'h00);
      begin
        @(posedge clk_i);
        pm.drive(1'b1, 1'b0, 6'h00);
      end
    join
    rdc(OFF_EXT_FLAGS, 32'h39);
    $display("test external pins done");
    pulse_sleep();
    rdc(OFF_EXT_FLAGS, 32'h39);
    wr(OFF_SYS_CTRL_2, 32'h08);
    pulse_sleep();
    chk(dt_req, 1'b1);
    rdc(OFF_EXT_FLAGS, 32'hB9);
    wr(OFF_EXT_FLAGS, 32'h08);
    rdc(OFF_EXT_FLAGS, 32'h38);
    $display("test direct transition done");
    w = 6'h00;
    flags = 6'h00;
    evw = 6'h00;
    for (int i = 0; i < 24; i++)
    begin
      tmp = xs();
      nw = (i == 0) ? 6'h3F : ((i == 1) ? 6'h00 : tmp[5:0]);
      flags |= edge_hits(w, nw, sel);
      evw |= edge_hits(w, nw, sel);
      pm.drive(ext3, ext0, nw);
      w = nw;
      settle();
      chk(wk_req, |flags);
      rdc(OFF_WAKE_FLAGS, {24'h0, 2'b11, flags});
      if (tmp[8])
      begin
        k = int'(tmp[11:9]) % 6;
        wr(OFF_WAKE_FLAGS, {24'h0, ~(8'h01 << k)});
        flags[k] = 1'b0;
      end
    end
    wr(OFF_INT_ENABLE, 32'h89);
    settle();
    chk(wk_req, 1'b0);
    $display("test wakeup pins done");
    rdc(OFF_EVT_STATUS, {23'h0, 3'b111, evw});
    chk(irq, 1'b1);
    wr(OFF_EVT_MASK, 32'h0);
    settle();
    chk(irq, 1'b0);
    wr(OFF_EVT_MASK, 32'h1FF);
    wr(OFF_EVT_STATUS, 32'h1FF);
    rdc(OFF_EVT_STATUS, 32'h0);
    settle();
    chk(irq, 1'b0);
    $display("test event interrupt done");
    report_and_stop();
  end
endmodule
`default_nettype wire
